// *** src/mls_mdio.sv ***
// serial management master toward the phy
// assumes start_i only while busy_o is low
`timescale 1ns/1ps
module mls_mdio
  import mls_pkg::*;
(
  // clock and reset
  input  wire logic          mclk_i,
  input  wire logic          reset_n_i,
  // request and answer
  input  wire logic          start_i,
  input  wire mls_mdio_req_t req_i,
  output logic               busy_o,
  output logic               done_o,
  output logic [15:0]        rdata_o,
  // management pins
  output logic               mdc_o,
  input  wire logic          mdio_i,
  output logic               mdio_o,
  output logic               mdio_oe_o
);
  mls_mdio_st_t st_q;
  logic [7:0]   div_q;
  logic [5:0]   bit_q;
  logic [63:0]  sh_q;
  logic         wr_q;
  logic         half;

  assign half      = (div_q == 8'(MDC_HALF_CYC - 1));
  assign busy_o    = (st_q == MD_RUN);
  assign mdio_o    = sh_q[63];
  assign mdio_oe_o = busy_o && (wr_q || bit_q <= MD_DRV_LAST);

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !busy_o || half) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // frame sequencing: drive after fall, sample at rise
  always_ff @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (!reset_n_i) begin
      st_q  <= MD_IDLE;
      mdc_o <= 1'b0;
      bit_q <= 6'h00;
      sh_q  <= 64'h0;
      wr_q  <= 1'b0;
    end else begin
      case (st_q)
        MD_IDLE: begin
          if (start_i) begin
            st_q  <= MD_RUN;
            wr_q  <= req_i.wr;
            bit_q <= 6'h00;
            sh_q  <= {32'hFFFF_FFFF, 2'b01, req_i.wr ? 2'b01 : 2'b10, req_i.phy, req_i.regad,
                      req_i.wr ? {2'b10, req_i.wdata} : 18'h3FFFF};
          end
        end
        MD_RUN: begin
          if (half) begin
            mdc_o <= !mdc_o;
            if (mdc_o) begin
              sh_q  <= {sh_q[62:0], 1'b1};
              bit_q <= bit_q + 6'h01;
              if (bit_q == MD_LAST) begin
                st_q   <= MD_IDLE;
                done_o <= 1'b1;
              end
            end
          end
        end
        default: st_q <= MD_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rdata_o <= 16'h0000;
    end else if (busy_o && half && !mdc_o && !wr_q && bit_q >= MD_DATA_FST) begin
      rdata_o <= {rdata_o[14:0], mdio_i};
    end
  end
endmodule

// *** src/mls_pkg.sv ***
// constants and carrier types for the lpi statistics and indirect mac csr block
// assumes a single 250 MHz system clock
package mls_pkg;
  localparam int CLK_NS       = 4;
  localparam int US_NS        = 1000;
  localparam int US_CYC       = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int MDC_HALF_NS  = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;
  // indirect indices
  localparam logic [7:0] IDX_CTRL = 8'h01, IDX_ADDRH = 8'h02, IDX_ADDRL = 8'h03;
  localparam logic [7:0] IDX_HASHH = 8'h04, IDX_HASHL = 8'h05, IDX_MII_ACC = 8'h06;
  localparam logic [7:0] IDX_MII_DATA = 8'h07, IDX_FLOW = 8'h08, IDX_VLAN1 = 8'h09;
  localparam logic [7:0] IDX_VLAN2 = 8'h0A, IDX_WUFF = 8'h0B, IDX_WUCSR = 8'h0C;
  localparam logic [7:0] IDX_COE = 8'h0D, IDX_TW_TX = 8'h0E, IDX_LPI_DLY = 8'h0F;
  // direct statistics offsets
  localparam logic [11:0] OFF_RX_CNT = 12'h0B0, OFF_RX_TIME = 12'h0B4;
  localparam logic [11:0] OFF_TX_CNT = 12'h0B8, OFF_TX_TIME = 12'h0BC;
  // mac control fields
  localparam int          CTRL_EEE_BIT = 25;
  localparam logic [31:0] CTRL_RESET   = 32'h0004_0000;
  localparam logic [31:0] CTRL_WMASK   = 32'h82BF_FFFF;
  // phy management access fields
  localparam int MII_BUSY_BIT = 0;
  localparam int MII_WR_BIT   = 1;
  localparam int MII_REG_LSB  = 6;
  localparam int MII_PHY_LSB  = 11;
  // serial management frame
  localparam logic [5:0] MD_DRV_LAST  = 6'd45;
  localparam logic [5:0] MD_DATA_FST  = 6'd48;
  localparam logic [5:0] MD_LAST      = 6'd63;
  typedef struct packed {
    logic        busy;
    logic        rnw;
    logic [21:0] rsvd;
    logic [7:0]  idx;
  } mls_cmd_t;
  typedef struct packed {
    logic        wr;
    logic [4:0]  phy;
    logic [4:0]  regad;
    logic [15:0] wdata;
  } mls_mdio_req_t;
  typedef enum logic {MD_IDLE, MD_RUN} mls_mdio_st_t;
  typedef enum logic {IND_IDLE, IND_EXEC} mls_ind_st_t;
endpackage

// *** src/mls_top.sv ***
// lpi statistics counters and indirect mac csr space
// assumes system csr logic outside presents command/data writes and a direct read port
// Function
// - count rising edges of phy receive lpi indication, 32 bits, read only
// - count microseconds receive lpi indication is asserted
// - count rising edges of our transmit lpi request to phy
// - count microseconds our transmit lpi request is asserted
// - all four counters held at zero while energy efficient enable is low
// - mac csrs reached only through indirect command and data registers
// - indices 01h to 0Fh select the fifteen mac registers in order
// - index 00h and 10h to FFh are reserved, nothing behind them
// - phy management access and data registers run serial phy accesses
// - mac control bit 25 is the energy efficient enable
`timescale 1ns/1ps
module mls_top
  import mls_pkg::*;
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_n_i,
  // indirect command and data registers
  input  wire logic        cmd_wr_i,
  input  wire mls_cmd_t    cmd_wdata_i,
  input  wire logic        data_wr_i,
  input  wire logic [31:0] data_wdata_i,
  output mls_cmd_t         cmd_o,
  output logic [31:0]      data_o,
  // direct statistics read
  input  wire logic        sys_rd_i,
  input  wire logic [11:0] sys_addr_i,
  output logic [31:0]      sys_rdata_o,
  // lpi signals
  input  wire logic        rx_lpi_ind_i,
  input  wire logic        tx_lpi_req_i,
  output logic             tx_lpi_req_o,
  output logic [31:0]      mac_control_o,
  // phy management pins
  output logic             mdc_o,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o
);
  mls_ind_st_t   st_q;
  mls_cmd_t      cmd_q;
  logic [31:0]   data_q;
  logic [31:0]   csr_q [1:15];
  logic [31:0]   rx_cnt_q;
  logic [31:0]   rx_time_q;
  logic [31:0]   tx_cnt_q;
  logic [31:0]   tx_time_q;
  logic [7:0]    pre_q;
  logic          tick;
  logic          rx_prev_q;
  logic          tx_req_q;
  logic          tx_prev_q;
  logic          eee;
  logic          do_wr;
  logic          md_start;
  logic          md_busy;
  logic          md_done;
  logic [15:0]   md_rdata;
  mls_mdio_req_t md_req;

  // index decode and readback
  function automatic logic valid_idx(input logic [7:0] idx);
    return idx >= IDX_CTRL && idx <= IDX_LPI_DLY;
  endfunction

  function automatic logic [31:0] step(input logic [31:0] v);
    return v + 32'h0000_0001;
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] idx);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (valid_idx(idx)) begin
      w = csr_q[idx[3:0]];
    end
    if (idx == IDX_MII_ACC) begin
      w[MII_BUSY_BIT] = md_busy;
    end
    return w;
  endfunction

  assign eee           = csr_q[1][CTRL_EEE_BIT];
  assign mac_control_o = csr_q[1];
  assign cmd_o         = cmd_q;
  assign data_o        = data_q;
  assign do_wr         = (st_q == IND_EXEC) && !cmd_q.rnw && valid_idx(cmd_q.idx);
  assign md_start      = do_wr && cmd_q.idx == IDX_MII_ACC && data_q[MII_BUSY_BIT] && !md_busy;
  assign md_req.wr     = data_q[MII_WR_BIT];
  assign md_req.phy    = data_q[MII_PHY_LSB +: 5];
  assign md_req.regad  = data_q[MII_REG_LSB +: 5];
  assign md_req.wdata  = csr_q[7][15:0];

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      st_q  <= IND_IDLE;
      cmd_q <= '0;
    end else begin
      case (st_q)
        IND_IDLE: begin
          if (cmd_wr_i && cmd_wdata_i.busy) begin
            cmd_q <= cmd_wdata_i;
            st_q  <= IND_EXEC;
          end
        end
        IND_EXEC: begin
          cmd_q.busy <= 1'b0;
          st_q       <= IND_IDLE;
        end
        default: st_q <= IND_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      data_q <= 32'h0000_0000;
    end else if (st_q == IND_EXEC && cmd_q.rnw) begin
      data_q <= rd_word(cmd_q.idx);
    end else if (data_wr_i && !cmd_q.busy) begin
      data_q <= data_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      for (int i = 1; i <= 15; i++) begin
        csr_q[i] <= 32'h0000_0000;
      end
      csr_q[1] <= CTRL_RESET;
    end else begin
      if (do_wr) begin
        csr_q[cmd_q.idx[3:0]] <= (cmd_q.idx == IDX_CTRL) ? (data_q & CTRL_WMASK) : data_q;
      end
      if (md_done && !csr_q[6][MII_WR_BIT]) begin
        csr_q[7] <= {16'h0000, md_rdata};
      end
    end
  end

  mls_mdio u_mdio (
    .mclk_i    (mclk_i),
    .reset_n_i (reset_n_i),
    .start_i   (md_start),
    .req_i     (md_req),
    .busy_o    (md_busy),
    .done_o    (md_done),
    .rdata_o   (md_rdata),
    .mdc_o     (mdc_o),
    .mdio_i    (mdio_i),
    .mdio_o    (mdio_o),
    .mdio_oe_o (mdio_oe_o)
  );

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !eee || tick) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end
  assign tick = (pre_q == 8'(US_CYC - 1));

  // lpi edge tracking and request to phy
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      rx_prev_q <= 1'b0;
      tx_req_q  <= 1'b0;
      tx_prev_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_lpi_ind_i;
      tx_req_q  <= tx_lpi_req_i && eee;
      tx_prev_q <= tx_req_q;
    end
  end
  assign tx_lpi_req_o = tx_req_q;

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !eee) begin
      rx_cnt_q <= 32'h0000_0000;
    end else if (rx_lpi_ind_i && !rx_prev_q) begin
      rx_cnt_q <= step(rx_cnt_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !eee) begin
      rx_time_q <= 32'h0000_0000;
    end else if (tick && rx_lpi_ind_i) begin
      rx_time_q <= step(rx_time_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !eee) begin
      tx_cnt_q <= 32'h0000_0000;
    end else if (tx_req_q && !tx_prev_q) begin
      tx_cnt_q <= step(tx_cnt_q);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i || !eee) begin
      tx_time_q <= 32'h0000_0000;
    end else if (tick && tx_req_q) begin
      tx_time_q <= step(tx_time_q);
    end
  end

  // direct read port for the counters
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      sys_rdata_o <= 32'h0000_0000;
    end else if (sys_rd_i) begin
      case (sys_addr_i)
        OFF_RX_CNT:  sys_rdata_o <= rx_cnt_q;
        OFF_RX_TIME: sys_rdata_o <= rx_time_q;
        OFF_TX_CNT:  sys_rdata_o <= tx_cnt_q;
        OFF_TX_TIME: sys_rdata_o <= tx_time_q;
        default:     sys_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  property p_rx_cnt;
    eee && rx_lpi_ind_i && !rx_prev_q |=> rx_cnt_q == $past(rx_cnt_q) + 32'h1;
  endproperty
  a_rx_cnt: assert property (p_rx_cnt)
    else $error("rx lpi rise not counted");

  property p_rx_time;
    eee && tick && rx_lpi_ind_i |=> rx_time_q == $past(rx_time_q) + 32'h1;
  endproperty
  a_rx_time: assert property (p_rx_time)
    else $error("rx lpi time not advanced");

  property p_tx_cnt;
    eee && tx_lpi_req_i ##1 eee && !tx_prev_q |=> tx_cnt_q == $past(tx_cnt_q) + 32'h1;
  endproperty
  a_tx_cnt: assert property (p_tx_cnt)
    else $error("tx lpi rise not counted");

  property p_tx_time;
    eee && tick && tx_req_q |=> tx_time_q == $past(tx_time_q) + 32'h1;
  endproperty
  a_tx_time: assert property (p_tx_time)
    else $error("tx lpi time not advanced");

  property p_clear;
    !eee |=> rx_cnt_q == 0 && rx_time_q == 0 && tx_cnt_q == 0 && tx_time_q == 0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("lpi counter not held clear");

  property p_cmd_done;
    st_q == IND_IDLE && cmd_wr_i && cmd_wdata_i.busy |=> cmd_q.busy ##1 !cmd_q.busy;
  endproperty
  a_cmd_done: assert property (p_cmd_done)
    else $error("indirect command busy not one cycle");

  property p_ctrl_read;
    st_q == IND_EXEC && cmd_q.rnw && cmd_q.idx == IDX_CTRL |=> data_q == $past(csr_q[1]);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read returned wrong word");

  property p_rsvd_read;
    st_q == IND_EXEC && cmd_q.rnw && !valid_idx(cmd_q.idx) |=> data_q == 32'h0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved index read not zero");

  property p_rsvd_write;
    st_q == IND_EXEC && !cmd_q.rnw && !valid_idx(cmd_q.idx) |=> $stable(csr_q[1]) && $stable(csr_q[15]);
  endproperty
  a_rsvd_write: assert property (p_rsvd_write)
    else $error("reserved index write changed a register");

  property p_mii_start;
    md_start |=> md_busy [*8];
  endproperty
  a_mii_start: assert property (p_mii_start)
    else $error("phy access did not start");

  property p_tick;
    tick |=> !tick [*8];
  endproperty
  a_tick: assert property (p_tick)
    else $error("microsecond tick too frequent");

  property p_eee_bit;
    do_wr && cmd_q.idx == IDX_CTRL |=> eee == $past(data_q[CTRL_EEE_BIT]);
  endproperty
  a_eee_bit: assert property (p_eee_bit)
    else $error("enable bit not taken from bit 25");

  c_rx_rise: cover property (eee && rx_lpi_ind_i && !rx_prev_q);
  c_tx_rise: cover property (eee && tx_req_q && !tx_prev_q);
  c_ind_rd: cover property (st_q == IND_EXEC && cmd_q.rnw);
  c_mii_done: cover property (md_done);
endmodule

// *** verif/mls_phy_model.sv ***
// phy side model: answers serial management frames
// assumes mdc idles low between frames and a pull-up on mdio
`timescale 1ns/1ps
module mls_phy_model #(
  parameter logic [15:0] RD_VALUE = 16'hC35A
) (
  // management pins
  input  wire logic   mdc_i,
  input  wire logic   mdio_i,
  output logic        mdio_o,
  output logic        mdio_oe_o,
  // last data word seen on the line
  output logic [15:0] wr_data_o
);
  int          cnt;
  realtime     last_t;
  logic [15:0] sh;
  logic        rd_q;
  initial begin
    cnt = 0;
    last_t = 0.0;
    sh = '0;
    rd_q = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
    wr_data_o = '0;
  end
  always @(posedge mdc_i) begin
    if ($realtime - last_t > 600.0) cnt = 0;
    last_t = $realtime;
    sh = {sh[14:0], mdio_i};
    cnt = cnt + 1;
    if (cnt == 36) rd_q = (sh[1:0] == 2'b10);
    // frame complete: restart the count so a quickly following frame lines up
    if (cnt == 64) begin
      wr_data_o = sh;
      cnt = 0;
    end
  end
  always @(negedge mdc_i) begin
    mdio_oe_o = rd_q && cnt >= 47 && cnt <= 63;
    mdio_o = (cnt == 47) ? 1'b0 : RD_VALUE[(63 - cnt) & 15];
    if (!mdio_oe_o) mdio_o = ~mdio_o;
  end
endmodule

// *** verif/mls_top_tb_top.sv ***
// self-checking bench for the lpi statistics and indirect csr block
// assumes the phy model answers management frames with its read value
`timescale 1ns/1ps
module mls_top_tb_top;
  import mls_pkg::*;
  logic        mclk_i, reset_n_i, cmd_wr_i, data_wr_i, sys_rd_i, rx_lpi_ind_i, tx_lpi_req_i;
  mls_cmd_t    cmd_wdata_i, cmd_o;
  logic [31:0] data_wdata_i, data_o, sys_rdata_o, mac_control_o, v;
  logic [11:0] sys_addr_i;
  logic        tx_lpi_req_o, mdc_o, mdio_o, mdio_oe_o, phy_o, phy_oe, mdio_w;
  logic [15:0] phy_wr;
  int          error_cnt, checks, n;
  // open drain line with pull-up
  assign mdio_w = mdio_oe_o ? mdio_o : (phy_oe ? phy_o : 1'b1);
  mls_top DUT (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_wr_i(cmd_wr_i), .cmd_wdata_i(cmd_wdata_i),
    .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i), .cmd_o(cmd_o), .data_o(data_o),
    .sys_rd_i(sys_rd_i), .sys_addr_i(sys_addr_i), .sys_rdata_o(sys_rdata_o),
    .rx_lpi_ind_i(rx_lpi_ind_i), .tx_lpi_req_i(tx_lpi_req_i), .tx_lpi_req_o(tx_lpi_req_o),
    .mac_control_o(mac_control_o), .mdc_o(mdc_o), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o));
  mls_phy_model PHY (.mdc_i(mdc_o), .mdio_i(mdio_w), .mdio_o(phy_o), .mdio_oe_o(phy_oe),
    .wr_data_o(phy_wr));
  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d checks", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // indirect access: data first for writes, then the command, then wait for busy to drop
  task automatic ind(input logic rnw, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    if (!rnw) begin
      data_wr_i = 1'b1;
      data_wdata_i = wd;
      step();
      data_wr_i = 1'b0;
    end
    cmd_wr_i = 1'b1;
    cmd_wdata_i = {1'b1, rnw, 22'h0, idx};
    step();
    cmd_wr_i = 1'b0;
    k = 0;
    while (cmd_o.busy !== 1'b0 && k < 20) begin
      step();
      k++;
    end
    if (cmd_o.busy !== 1'b0) begin
      error_cnt++;
      finish_test();
    end else begin
      rd = data_o;
    end
  endtask
  task automatic sread(input logic [11:0] a, output logic [31:0] rd);
    sys_rd_i = 1'b1;
    sys_addr_i = a;
    step();
    rd = sys_rdata_o;
    sys_rd_i = 1'b0;
    step();
  endtask
  task automatic mii_wait();
    n = 0;
    v = 32'h1;
    while (v[MII_BUSY_BIT] !== 1'b0 && n < 400) begin
      repeat (50) step();
      ind(1'b1, IDX_MII_ACC, 32'h0, v);
      n++;
    end
    if (v[MII_BUSY_BIT] !== 1'b0) begin
      error_cnt++;
      finish_test();
    end
  endtask
  initial begin
    error_cnt = 0;
    checks = 0;
    {reset_n_i, cmd_wr_i, data_wr_i, sys_rd_i, rx_lpi_ind_i, tx_lpi_req_i} = '0;
    cmd_wdata_i = '0;
    data_wdata_i = '0;
    sys_addr_i = '0;
    repeat (10) step();
    reset_n_i = 1'b1;
    check(mac_control_o, CTRL_RESET);
    check({30'h0, mdc_o, mdio_oe_o}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      sread(OFF_RX_CNT + 12'(i * 4), v);
      check(v, 32'h0);
    end
    for (int i = 2; i < 16; i++) begin
      if (i inside {6, 7, 11, 12, 13}) continue;
      ind(1'b0, 8'(i), {4{8'(i)}}, v);
      ind(1'b1, 8'(i), 32'h0, v);
      check(v, {4{8'(i)}});
    end
    for (int i = 0; i < 3; i++) begin
      ind(1'b0, (i == 0) ? 8'h00 : ((i == 1) ? 8'h10 : 8'hFF), 32'hFFFF_FFFF, v);
      ind(1'b1, (i == 0) ? 8'h00 : ((i == 1) ? 8'h10 : 8'hFF), 32'h0, v);
      check(v, 32'h0);
    end
    ind(1'b1, IDX_ADDRH, 32'h0, v);
    check(v, 32'h0202_0202);
    ind(1'b1, IDX_LPI_DLY, 32'h0, v);
    check(v, 32'h0F0F_0F0F);
    ind(1'b0, IDX_CTRL, 32'hFFFF_FFFF, v);
    ind(1'b1, IDX_CTRL, 32'h0, v);
    check(v, CTRL_WMASK);
    ind(1'b0, IDX_CTRL, CTRL_RESET | (32'h1 << CTRL_EEE_BIT), v);
    check(mac_control_o, CTRL_RESET | (32'h1 << CTRL_EEE_BIT));
    // both lpi signals held for exactly three microseconds
    rx_lpi_ind_i = 1'b1;
    tx_lpi_req_i = 1'b1;
    step();
    check({31'h0, tx_lpi_req_o}, 32'h1);
    repeat (3 * US_CYC - 1) step();
    rx_lpi_ind_i = 1'b0;
    tx_lpi_req_i = 1'b0;
    repeat (3) step();
    sread(OFF_RX_TIME, v);
    check(v, 32'd3);
    sread(OFF_TX_TIME, v);
    check(v, 32'd3);
    repeat (3) begin
      rx_lpi_ind_i = 1'b1;
      tx_lpi_req_i = 1'b1;
      repeat (2) step();
      rx_lpi_ind_i = 1'b0;
      tx_lpi_req_i = 1'b0;
      repeat (2) step();
    end
    repeat (2) step();
    sread(OFF_RX_CNT, v);
    check(v, 32'd4);
    sread(OFF_TX_CNT, v);
    check(v, 32'd4);
    ind(1'b0, IDX_CTRL, CTRL_RESET, v);
    rx_lpi_ind_i = 1'b1;
    tx_lpi_req_i = 1'b1;
    repeat (3) step();
    check({31'h0, tx_lpi_req_o}, 32'h0);
    rx_lpi_ind_i = 1'b0;
    tx_lpi_req_i = 1'b0;
    for (int i = 0; i < 4; i++) begin
      sread(OFF_RX_CNT + 12'(i * 4), v);
      check(v, 32'h0);
    end
    // phy write then phy read through the management registers
    ind(1'b0, IDX_MII_DATA, 32'h0000_A5C3, v);
    ind(1'b0, IDX_MII_ACC, (32'd1 << MII_PHY_LSB) | (32'd2 << MII_REG_LSB) | 32'h3, v);
    mii_wait();
    check({16'h0, phy_wr}, 32'h0000_A5C3);
    ind(1'b0, IDX_MII_ACC, (32'd1 << MII_PHY_LSB) | (32'd2 << MII_REG_LSB) | 32'h1, v);
    mii_wait();
    ind(1'b1, IDX_MII_DATA, 32'h0, v);
    check({16'h0, v[15:0]}, 32'h0000_C35A);
    finish_test();
  end
endmodule
